// ### shared/floppy_drive_params.svh
// register offsets, field positions, reset values and timing counts
`ifndef FLOPPY_DRIVE_PARAMS_SVH
`define FLOPPY_DRIVE_PARAMS_SVH
`define FD_ADDR_DOC 12'h000
`define FD_ADDR_RATECFG 12'h004
`define FD_ADDR_RATESEL 12'h008
`define FD_ADDR_SEEK 12'h00c
`define FD_ADDR_STEPRATE 12'h010
`define FD_ADDR_WRCTL 12'h014
`define FD_ADDR_WRDATA 12'h018
`define FD_ADDR_STATUS 12'h01c
`define FD_ADDR_SIDE 12'h020
`define FD_DOC_RESET 8'h00
`define FD_DOC_QUAD_BIT 2
`define FD_DOC_ENABLE_BIT 3
`define FD_STEP_US 1
`define FD_CLK_MHZ 10
`define FD_STEP_PULSE_CYC (`FD_STEP_US * `FD_CLK_MHZ)
`define FD_DIR_SETUP_CYC 16'h000a
`define FD_STEPRATE_RESET 16'h03e8
`define FD_CELL_RESET 8'h14
`endif

// ### shared/floppy_drive_pkg.sv
// types shared by the floppy drive interface
package floppy_drive_pkg;
    typedef enum logic [3:0] {
        SEEK_IDLE = 4'b0001,
        SEEK_SETUP = 4'b0010,
        SEEK_PULSE = 4'b0100,
        SEEK_GAP = 4'b1000
    } seek_state_type;
    typedef enum logic [1:0] {
        PRECOMP_NONE = 2'h0,
        PRECOMP_ONE = 2'h1,
        PRECOMP_TWO = 2'h2,
        PRECOMP_THREE = 2'h3
    } precomp_type;
endpackage : floppy_drive_pkg

// ### shared/write_path_if.sv
// signals between the register core and the write serialiser
`timescale 1ns/1ns
interface write_path_if;
    logic gate_on;
    logic [7:0] data;
    logic [7:0] cell_cycles;
    floppy_drive_pkg::precomp_type precomp;
    logic byte_ready;
    logic byte_taken;
    logic serial_out;
    modport core (output gate_on, data, cell_cycles, precomp, byte_ready,
                  input byte_taken, serial_out);
    modport serial (input gate_on, data, cell_cycles, precomp, byte_ready,
                    output byte_taken, serial_out);
endinterface : write_path_if

// ### logic/write_serialiser.sv
// shifts write bytes out as pre-compensated pulses
`timescale 1ns/1ns
`include "floppy_drive_params.svh"
module write_serialiser (
    input wire logic i_clk,
    input wire logic i_rst,
    write_path_if.serial wp
);
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    logic loaded_q;
    logic [7:0] cell_q;
    logic out_q;
    logic [7:0] fire_at;

    // pulse position in the cell moves earlier by the precomp amount
    always_comb begin
        fire_at = 8'h01 + {6'h00, wp.precomp};
    end

    // byte load and bit advance
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_q <= 8'h00;
            bit_q <= 3'h0;
            loaded_q <= 1'b0;
            cell_q <= 8'h00;
        end else if (!wp.gate_on) begin
            loaded_q <= 1'b0;
            cell_q <= 8'h00;
        end else if (!loaded_q) begin
            if (wp.byte_ready) begin
                shift_q <= wp.data;
                bit_q <= 3'h7;
                loaded_q <= 1'b1;
                cell_q <= wp.cell_cycles;
            end
        end else if (cell_q == 8'h01) begin
            cell_q <= wp.cell_cycles;
            shift_q <= {shift_q[6:0], 1'b0};
            bit_q <= bit_q - 3'h1;
            if (bit_q == 3'h0) begin
                loaded_q <= 1'b0;
            end
        end else begin
            cell_q <= cell_q - 8'h01;
        end
    end

    // one clock pulse per set bit, placed by precompensation
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            out_q <= 1'b0;
        end else begin
            out_q <= wp.gate_on && loaded_q && shift_q[7] &&
                     (cell_q == fire_at);
        end
    end

    assign wp.byte_taken = wp.gate_on && !loaded_q && wp.byte_ready;
    assign wp.serial_out = out_q;
endmodule : write_serialiser

// ### logic/floppy_drive_interface.sv
// drive-side pin logic of the floppy disk controller with apb registers
// Notes on behaviour
// - density output shows high or low rate
// - direction active steps inward, inactive outward
// - drive selects decode control bits one, zero, active low
// - rate bit follows last written rate register
// - side select low accesses side one
// - motor enables active low from bits five-four
// - quad mode: selects pass bits one, zero; motor zero active on any of bits seven-four
// - step pulses at software rate during seek
// - write data precompensated, setting from software
// - write gate glitch free across power cycling
`timescale 1ns/1ns
`include "floppy_drive_params.svh"
module floppy_drive_interface (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_read_data_in,
    input wire logic i_index_in,
    input wire logic i_track_zero_in,
    input wire logic i_write_protect_in,
    input wire logic i_door_opened_in,
    input wire logic i_media_sense_in,
    output logic o_density_indicator_out,
    output logic o_drive_select_hi,
    output logic o_drive_select_lo,
    output logic o_rate_bit_out,
    output logic o_side_select_out,
    output logic o_dir_out,
    output logic o_step_out,
    output logic o_write_data_out,
    output logic o_write_gate_out,
    output logic o_motor_on_hi,
    output logic o_motor_on_lo
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] doc_q;
    logic [1:0] rate_q;
    logic [15:0] step_period_q;
    logic [7:0] cell_q;
    floppy_drive_pkg::precomp_type precomp_q;
    logic gate_req_q;
    logic gate_q;
    logic [7:0] wbyte_q;
    logic wbyte_full_q;
    logic side_q;
    logic dir_q;
    logic [7:0] steps_left_q;
    logic [15:0] step_cnt_q;
    floppy_drive_pkg::seek_state_type seek_q;
    logic [15:0] index_count_q;
    logic step_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic seek_start;
    logic [31:0] rdata_d;

    write_path_if wp ();

    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, unmapped addresses raise pslverr
    assign wr_en = i_psel && i_penable && i_pwrite && addr_ok;
    assign rd_en = i_psel && !i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok;
    assign seek_start = wr_en && hit(i_paddr, `FD_ADDR_SEEK);

    always_comb begin
        addr_ok = hit(i_paddr, `FD_ADDR_DOC) ||
                  hit(i_paddr, `FD_ADDR_RATECFG) ||
                  hit(i_paddr, `FD_ADDR_RATESEL) ||
                  hit(i_paddr, `FD_ADDR_SEEK) ||
                  hit(i_paddr, `FD_ADDR_STEPRATE) ||
                  hit(i_paddr, `FD_ADDR_WRCTL) ||
                  hit(i_paddr, `FD_ADDR_WRDATA) ||
                  hit(i_paddr, `FD_ADDR_STATUS) ||
                  hit(i_paddr, `FD_ADDR_SIDE);
    end

    // read multiplexer
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(i_paddr, `FD_ADDR_DOC)) begin
            rdata_d = {24'h000000, doc_q};
        end else if (hit(i_paddr, `FD_ADDR_RATECFG) ||
                     hit(i_paddr, `FD_ADDR_RATESEL)) begin
            rdata_d = {30'h00000000, rate_q};
        end else if (hit(i_paddr, `FD_ADDR_SEEK)) begin
            rdata_d = {23'h000000, dir_q, steps_left_q};
        end else if (hit(i_paddr, `FD_ADDR_STEPRATE)) begin
            rdata_d = {16'h0000, step_period_q};
        end else if (hit(i_paddr, `FD_ADDR_WRCTL)) begin
            rdata_d = {21'h000000, gate_req_q, precomp_q, cell_q};
        end else if (hit(i_paddr, `FD_ADDR_WRDATA)) begin
            rdata_d = {23'h000000, wbyte_full_q, wbyte_q};
        end else if (hit(i_paddr, `FD_ADDR_SIDE)) begin
            rdata_d = {31'h00000000, side_q};
        end else if (hit(i_paddr, `FD_ADDR_STATUS)) begin
            rdata_d = {index_count_q, 8'h00,
                       seek_q != floppy_drive_pkg::SEEK_IDLE,
                       i_read_data_in, i_media_sense_in,
                       i_door_opened_in, i_write_protect_in,
                       i_track_zero_in, i_index_in, gate_q};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            o_prdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // drive output control and side select
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            doc_q <= `FD_DOC_RESET;
            side_q <= 1'b0;
        end else begin
            if (wr_en && hit(i_paddr, `FD_ADDR_DOC)) begin
                doc_q <= i_pwdata[7:0];
            end
            if (wr_en && hit(i_paddr, `FD_ADDR_SIDE)) begin
                side_q <= i_pwdata[0];
            end
        end
    end

    // both rate registers write one shared copy, so the last write wins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rate_q <= 2'h2;
        end else if (wr_en && (hit(i_paddr, `FD_ADDR_RATECFG) ||
                               hit(i_paddr, `FD_ADDR_RATESEL))) begin
            rate_q <= i_pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive: selects, motors, rate, density, side
    always_comb begin
        if (doc_q[`FD_DOC_QUAD_BIT]) begin
            o_drive_select_lo = doc_q[0];
            o_drive_select_hi = doc_q[1];
            o_motor_on_lo = !(|doc_q[7:4]);
            o_motor_on_hi = 1'b1;
        end else begin
            o_drive_select_lo = !(doc_q[1:0] == 2'h0);
            o_drive_select_hi = !(doc_q[1:0] == 2'h1);
            o_motor_on_lo = !doc_q[4];
            o_motor_on_hi = !doc_q[5];
        end
    end
    // rates 00 500k, 11 1m/2m high; 01 300k, 10 250k low
    assign o_density_indicator_out = (rate_q == 2'h0) ||
                                     (rate_q == 2'h3);
    assign o_rate_bit_out = rate_q[0];
    assign o_side_select_out = !side_q;

    ////////////////////////////////////////////////////////////////////////
    // step rate setting
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            step_period_q <= `FD_STEPRATE_RESET;
        end else if (wr_en && hit(i_paddr, `FD_ADDR_STEPRATE)) begin
            step_period_q <= i_pwdata[15:0];
        end
    end

    // seek sequencer: direction set, settle, then pulses at the set rate
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seek_q <= floppy_drive_pkg::SEEK_IDLE;
            dir_q <= 1'b0;
            steps_left_q <= 8'h00;
            step_cnt_q <= 16'h0000;
            step_q <= 1'b0;
        end else begin
            unique case (seek_q)
                floppy_drive_pkg::SEEK_IDLE: begin
                    step_q <= 1'b0;
                    if (seek_start && i_pwdata[7:0] != 8'h00) begin
                        dir_q <= i_pwdata[8];
                        steps_left_q <= i_pwdata[7:0];
                        step_cnt_q <= `FD_DIR_SETUP_CYC;
                        seek_q <= floppy_drive_pkg::SEEK_SETUP;
                    end
                end
                floppy_drive_pkg::SEEK_SETUP: begin
                    if (step_cnt_q <= 16'h0001) begin
                        step_q <= 1'b1;
                        step_cnt_q <= 16'(`FD_STEP_PULSE_CYC);
                        seek_q <= floppy_drive_pkg::SEEK_PULSE;
                    end else begin
                        step_cnt_q <= step_cnt_q - 16'h0001;
                    end
                end
                floppy_drive_pkg::SEEK_PULSE: begin
                    if (step_cnt_q <= 16'h0001) begin
                        step_q <= 1'b0;
                        steps_left_q <= steps_left_q - 8'h01;
                        step_cnt_q <= step_period_q;
                        seek_q <= (steps_left_q == 8'h01) ?
                                  floppy_drive_pkg::SEEK_IDLE :
                                  floppy_drive_pkg::SEEK_GAP;
                    end else begin
                        step_cnt_q <= step_cnt_q - 16'h0001;
                    end
                end
                floppy_drive_pkg::SEEK_GAP: begin
                    if (step_cnt_q <= 16'h0001) begin
                        step_q <= 1'b1;
                        step_cnt_q <= 16'(`FD_STEP_PULSE_CYC);
                        seek_q <= floppy_drive_pkg::SEEK_PULSE;
                    end else begin
                        step_cnt_q <= step_cnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end
    assign o_dir_out = dir_q;
    assign o_step_out = step_q;

    ////////////////////////////////////////////////////////////////////////
    // index counter shows the drive turning
    logic index_d1_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            index_d1_q <= 1'b0;
            index_count_q <= 16'h0000;
        end else begin
            index_d1_q <= i_index_in;
            if (i_index_in && !index_d1_q) begin
                index_count_q <= index_count_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write control and byte holding register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cell_q <= `FD_CELL_RESET;
            precomp_q <= floppy_drive_pkg::PRECOMP_NONE;
            gate_req_q <= 1'b0;
        end else if (wr_en && hit(i_paddr, `FD_ADDR_WRCTL)) begin
            cell_q <= i_pwdata[7:0];
            precomp_q <= floppy_drive_pkg::precomp_type'(i_pwdata[9:8]);
            gate_req_q <= i_pwdata[10];
        end
    end

    // a software write wins over a serialiser take in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wbyte_q <= 8'h00;
            wbyte_full_q <= 1'b0;
        end else if (wr_en && hit(i_paddr, `FD_ADDR_WRDATA)) begin
            wbyte_q <= i_pwdata[7:0];
            wbyte_full_q <= 1'b1;
        end else if (wp.byte_taken) begin
            wbyte_full_q <= 1'b0;
        end
    end

    // gate only from a flop cleared by reset, needs request, enable bit and no write protect
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gate_q <= 1'b0;
        end else begin
            gate_q <= gate_req_q && doc_q[`FD_DOC_ENABLE_BIT] &&
                      !i_write_protect_in;
        end
    end
    assign o_write_gate_out = gate_q;

    assign wp.gate_on = gate_q;
    assign wp.data = wbyte_q;
    assign wp.cell_cycles = cell_q;
    assign wp.precomp = precomp_q;
    assign wp.byte_ready = wbyte_full_q;
    assign o_write_data_out = wp.serial_out;

    write_serialiser u_ser (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .wp(wp.serial)
    );
endmodule : floppy_drive_interface

// ### testbench/floppy_drive_interface_sva.sv
// concurrent checks on the drive-side pins of the interface
`timescale 1ns/1ns
`include "floppy_drive_params.svh"
module floppy_drive_interface_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_write_protect_in,
    input wire logic o_density_indicator_out,
    input wire logic o_drive_select_hi,
    input wire logic o_drive_select_lo,
    input wire logic o_rate_bit_out,
    input wire logic o_side_select_out,
    input wire logic o_dir_out,
    input wire logic o_step_out,
    input wire logic o_write_data_out,
    input wire logic o_write_gate_out,
    input wire logic o_motor_on_hi,
    input wire logic o_motor_on_lo
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic wr, rate_wr, dens_e, rate_e, side_e;
    logic [1:0] sel_e, mot_e;
    // expected pin levels worked out from the write data
    assign wr = i_psel && i_penable && i_pwrite;
    assign rate_wr = wr && (i_paddr == `FD_ADDR_RATECFG ||
        i_paddr == `FD_ADDR_RATESEL);
    assign dens_e = ~^i_pwdata[1:0];
    assign rate_e = i_pwdata[0];
    assign side_e = ~i_pwdata[0];
    assign sel_e = i_pwdata[2] ? i_pwdata[1:0] :
        {i_pwdata[1:0] != 2'h1, i_pwdata[1:0] != 2'h0};
    assign mot_e = i_pwdata[2] ? {1'b1, ~|i_pwdata[7:4]} : ~i_pwdata[5:4];
    ////////////////////////////////////////
    a_density_rate: assert property (rate_wr |=>
        o_density_indicator_out == $past(dens_e))
        else $error("density pin wrong after rate write");
    a_rate_last: assert property (rate_wr |=>
        o_rate_bit_out == $past(rate_e))
        else $error("rate bit wrong after rate write");
    a_select_doc: assert property (wr && i_paddr == `FD_ADDR_DOC |=>
        {o_drive_select_hi, o_drive_select_lo} == $past(sel_e))
        else $error("drive selects wrong after control write");
    a_motor_doc: assert property (wr && i_paddr == `FD_ADDR_DOC |=>
        {o_motor_on_hi, o_motor_on_lo} == $past(mot_e))
        else $error("motor enables wrong after control write");
    a_side_low: assert property (wr && i_paddr == `FD_ADDR_SIDE |=>
        o_side_select_out == $past(side_e))
        else $error("side select wrong after side write");
    a_step_width: assert property ($rose(o_step_out) |->
        o_step_out [*8] ##1 o_step_out ##1 o_step_out ##1 !o_step_out)
        else $error("step pulse width wrong");
    a_dir_steady: assert property (o_step_out |-> $stable(o_dir_out))
        else $error("direction moved during a step pulse");
    a_gate_wp: assert property ($rose(o_write_gate_out) |->
        !$past(i_write_protect_in))
        else $error("write gate rose on a protected disk");
    a_wdata_pulse: assert property (o_write_data_out |=>
        !o_write_data_out)
        else $error("write data pulse longer than a cycle");
endmodule : floppy_drive_interface_sva
bind floppy_drive_interface floppy_drive_interface_sva chk (.*);

// ### testbench/drive_model.sv
// behavioural model of the attached disk drives
`timescale 1ns/1ns
module drive_model (
    input wire logic i_clk,
    input wire logic i_step,
    input wire logic i_dir,
    input wire logic i_wp,
    input wire logic i_door,
    input wire logic i_media,
    output logic o_track_zero,
    output logic o_index,
    output logic o_wp,
    output logic o_door,
    output logic o_media,
    output logic o_rdata,
    output logic [7:0] o_track
);
    logic [7:0] trk = 8'h01;
    logic [5:0] rot = 6'h00;
    // head moves one track per step, inward on direction high
    always @(posedge i_step) begin
        if (i_dir) trk <= trk + 8'h01;
        else if (trk != 8'h00) trk <= trk - 8'h01;
    end
    // disk rotation drives the index mark and a changing read stream
    always @(posedge i_clk) begin
        rot <= rot + 6'h01;
    end
    assign o_track = trk;
    assign o_track_zero = (trk == 8'h00);
    assign o_index = (rot == 6'h00);
    assign o_rdata = rot[1] ^ rot[3];
    assign o_wp = i_wp;
    assign o_door = i_door;
    assign o_media = i_media;
endmodule : drive_model

// ### testbench/tb_floppy_drive_interface.sv
// self-checking bench for the floppy drive interface
`timescale 1ns/1ns
`include "floppy_drive_params.svh"
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin fails++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_floppy_drive_interface;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, prd;
    logic prdy, perr, rdat, idx, tz, wp, dc, ms, dens, shi, slo, rb, side;
    logic dir, step, wdat, gate, mhi, mlo, wps = 0, door = 0, med = 0;
    logic [7:0] tr;
    logic [31:0] r;
    logic e;
    int fails = 0, n_tests = 0, cyc = 0, lastp = 0, npul = 0;
    ////////////////////////////////////////
    always #50 clk = ~clk;
    // time stamps of write data pulses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wdat) begin
            lastp <= cyc;
            npul <= npul + 1;
        end
    end
    floppy_drive_interface dut (.i_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
        .i_read_data_in(rdat), .i_index_in(idx), .i_track_zero_in(tz),
        .i_write_protect_in(wp), .i_door_opened_in(dc),
        .i_media_sense_in(ms), .o_density_indicator_out(dens),
        .o_drive_select_hi(shi), .o_drive_select_lo(slo),
        .o_rate_bit_out(rb), .o_side_select_out(side), .o_dir_out(dir),
        .o_step_out(step), .o_write_data_out(wdat),
        .o_write_gate_out(gate), .o_motor_on_hi(mhi), .o_motor_on_lo(mlo));
    drive_model drv (.i_clk(clk), .i_step(step), .i_dir(dir), .i_wp(wps),
        .i_door(door), .i_media(med), .o_track_zero(tz), .o_index(idx),
        .o_wp(wp), .o_door(dc), .o_media(ms), .o_rdata(rdat), .o_track(tr));
    ////////////////////////////////////////
    task automatic summarize();
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            summarize();
        end
        r = prd;
        e = perr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask : apb
    task automatic t_reset();
        `CHK("selects", 2'b10, {shi, slo})
        `CHK("motors", 2'b11, {mhi, mlo})
        `CHK("density", 1'b0, dens)
        `CHK("gate", 1'b0, gate)
    endtask : t_reset
    task automatic t_doc();
        logic [11:0] tab [4];
        tab = '{12'h10a, 12'h215, 12'h07f, 12'h86a};
        foreach (tab[i]) begin
            apb(1, `FD_ADDR_DOC, {24'h0, tab[i][11:4]});
            `CHK("selects", tab[i][3:2], {shi, slo})
            `CHK("motors", tab[i][1:0], {mhi, mlo})
        end
    endtask : t_doc
    task automatic t_rate();
        for (int i = 0; i < 4; i++) begin
            apb(1, i[0] ? `FD_ADDR_RATECFG : `FD_ADDR_RATESEL, i);
            `CHK("density", (i == 0 || i == 3), dens)
            `CHK("rate bit", i[0], rb)
        end
    endtask : t_rate
    task automatic t_side();
        apb(1, `FD_ADDR_SIDE, 32'h1);
        `CHK("side", 1'b0, side)
        apb(1, `FD_ADDR_SIDE, 32'h0);
        `CHK("side", 1'b1, side)
    endtask : t_side
    // seek, counting step pulses and watching direction at each
    task automatic t_seek(input logic [7:0] st, input logic dn,
        input logic [7:0] trk);
        int c;
        logic p;
        c = 0;
        p = 0;
        apb(1, `FD_ADDR_SEEK, {23'h0, dn, st});
        repeat (400) begin
            @(negedge clk);
            if (step && !p) begin
                c++;
                `CHK("dir", dn, dir)
            end
            p = step;
        end
        @(posedge clk);
        `CHK("steps", st, 8'(c))
        `CHK("track", trk, tr)
        apb(0, `FD_ADDR_STATUS, 32'h0);
        `CHK("busy", 1'b0, r[7])
    endtask : t_seek
    task automatic t_status();
        door <= 1;
        med <= 1;
        repeat (3) @(posedge clk);
        apb(0, `FD_ADDR_STATUS, 32'h0);
        `CHK("status", 3'b111, {r[5:4], r[2]})
        `CHK("index count", 1'b1, r[31:16] != 16'h0)
        apb(0, 12'h024, 32'h0);
        `CHK("slverr", 1'b1, e)
        `CHK("unmapped", 32'h0, r)
    endtask : t_status
    // precomp shifts the pulse, protect drops the gate
    task automatic t_write();
        int d0, t, n0;
        d0 = 0;
        apb(1, `FD_ADDR_DOC, 32'h08);
        for (int p = 0; p < 4; p++) begin
            apb(1, `FD_ADDR_WRCTL, 32'h404 | (p << 8));
            t = cyc;
            apb(1, `FD_ADDR_WRDATA, 32'h80);
            repeat (60) @(posedge clk);
            if (p == 0) d0 = lastp - t;
            `CHK("precomp", p, d0 - (lastp - t))
            `CHK("gate", 1'b1, gate)
        end
        n0 = npul;
        apb(1, `FD_ADDR_WRDATA, 32'ha5);
        repeat (60) @(posedge clk);
        `CHK("pulses", 4, npul - n0)
        wps <= 1;
        repeat (3) @(posedge clk);
        `CHK("gate", 1'b0, gate)
        apb(1, `FD_ADDR_WRCTL, 32'h0);
        wps <= 0;
    endtask : t_write
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_reset();
        t_doc();
        t_rate();
        t_side();
        apb(1, `FD_ADDR_STEPRATE, 32'h14);
        t_seek(8'h01, 1'b0, 8'h00);
        t_status();
        t_seek(8'h03, 1'b1, 8'h03);
        t_write();
        summarize();
    end
endmodule : tb_floppy_drive_interface
